/* File: hdl/wcb_pkg.sv */
// Constants and carrier types shared by the write-combining buffer block
package wcb_pkg;

	// ---------------------------------------------------------------
	// Sizes and counts
	// ---------------------------------------------------------------
	localparam int NUM_BUF       = 8;  // Physical buffers built
	localparam int BUF_W         = 3;  // Buffer index width
	localparam int BASE_BUF      = 6;  // Buffers on the base revision
	localparam int LATE_BUF      = 8;  // Buffers on the later revision
	localparam int DRAIN_RESERVE = 2;  // Buffers that may be draining
	localparam int QW_W          = 3;  // Quadword index width
	localparam int LINE_W        = 26; // Line address width (64-byte lines)
	localparam int MEM_AW        = 6;  // Line store address width
	localparam int LINE_BITS     = 64; // Byte mask width of a line

	// ---------------------------------------------------------------
	// Reset and fixed values
	// ---------------------------------------------------------------
	localparam logic [63:0] MASK_EMPTY = 64'h0;
	localparam logic [63:0] MASK_FULL  = 64'hffffffffffffffff;
	localparam logic [7:0]  BE_ALL     = 8'hff;
	localparam logic [2:0]  QW_LAST    = 3'h7;

	// ---------------------------------------------------------------
	// Enumerations
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		mt_writeback   = 2'h0, // Cacheable store that missed first level
		mt_combining   = 2'h1, // combining_memory_type
		mt_uncacheable = 2'h2  // uncacheable_memory_type
	} mem_type_t;

	typedef enum logic [1:0] {
		own_none    = 2'h0, // No ownership read needed or done
		own_pending = 2'h1, // Ownership read waiting to be issued
		own_issued  = 2'h3  // Ownership read out, fill awaited
	} own_t;

	typedef enum logic [1:0] {
		dr_idle = 2'h0,
		dr_load = 2'h1,
		dr_send = 2'h3
	} drain_t;

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [LINE_W-1:0] line;
		logic [QW_W-1:0]   qword;
		logic [63:0]       data;
		logic [7:0]        be;
		mem_type_t         mtype;
	} store_t;

	typedef struct packed {
		logic [LINE_W-1:0] line;
		logic [BUF_W-1:0]  slot;
	} own_req_t;

	typedef struct packed {
		logic [BUF_W-1:0] slot;
		logic [QW_W-1:0]  qword;
		logic [63:0]      data;
		logic             last;
	} fill_t;

	typedef struct packed {
		logic [LINE_W-1:0] line;
		logic [QW_W-1:0]   qword;
		logic [63:0]       data;
		logic [7:0]        be;
		logic              full;
		logic              last;
	} beat_t;

	typedef struct packed {
		logic              valid;
		logic [LINE_W-1:0] line;
		mem_type_t         mtype;
		logic [63:0]       mask;
		own_t              own;
		logic              evict;
	} wcbuf_t;

endpackage

/* File: hdl/wcb_line_store.sv */
// Line data store: two byte-enabled write ports, one registered read port
`timescale 1ns/100ps
module wcb_line_store (
	input  wire logic                           clk,
	input  wire logic                           st_we,
	input  wire logic [wcb_pkg::MEM_AW-1:0]     st_addr,
	input  wire logic [7:0]                     st_be,
	input  wire logic [63:0]                    st_data,
	input  wire logic                           fl_we,
	input  wire logic [wcb_pkg::MEM_AW-1:0]     fl_addr,
	input  wire logic [7:0]                     fl_be,
	input  wire logic [63:0]                    fl_data,
	input  wire logic [wcb_pkg::MEM_AW-1:0]     rd_addr,
	output logic      [63:0]                    rd_data
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [63:0][63:0] mem; // One quadword per entry
		logic [63:0]       rd;  // Registered read data
	} store_state_t;

	store_state_t s_reg;
	store_state_t s_next;

	// Store port wins per byte so a fill never overwrites a new store
	always_comb begin
		s_next = s_reg;
		s_next.rd = s_reg.mem[rd_addr];
		for (int k = 0; k < 8; k++) begin
			if (fl_we && fl_be[k]) begin
				s_next.mem[fl_addr][k*8 +: 8] = fl_data[k*8 +: 8];
			end
			if (st_we && st_be[k]) begin
				s_next.mem[st_addr][k*8 +: 8] = st_data[k*8 +: 8];
			end
		end
	end

	// Data needs no reset: masks decide which bytes are meaningful
	always_ff @(posedge clk) begin
		s_reg <= s_next;
	end

	assign rd_data = s_reg.rd;

endmodule // wcb_line_store

/* File: hdl/write_combining_buffers.sv */
// Write-combining buffers between core store misses and the outer hierarchy
`timescale 1ns/100ps
module write_combining_buffers (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              late_rev,
	input  wire logic              st_valid,
	input  wire wcb_pkg::store_t   st_in,
	output logic                   st_ready,
	output logic                   own_valid,
	output wcb_pkg::own_req_t      own_req,
	input  wire logic              own_ready,
	input  wire logic              fill_valid,
	input  wire wcb_pkg::fill_t    fill_in,
	output logic                   wr_valid,
	output wcb_pkg::beat_t         wr_beat,
	input  wire logic              wr_ready
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		wcb_pkg::wcbuf_t [wcb_pkg::NUM_BUF-1:0]        b;    // Buffers
		logic [wcb_pkg::NUM_BUF-1:0][wcb_pkg::NUM_BUF-1:0] blk; // Holds
		logic                            eight; // Later revision strap
		logic                            pend;  // Store held for decision
		wcb_pkg::store_t                 st;    // The held store
		logic                            rdy;   // Store port ready
		logic                            own_v; // Ownership read offered
		wcb_pkg::own_req_t               own;   // Its line and buffer
		wcb_pkg::drain_t                 dr;    // Drain sequencer
		logic [wcb_pkg::BUF_W-1:0]       dslot; // Buffer being drained
		logic [wcb_pkg::QW_W-1:0]        dq;    // Quadword being drained
		logic [1:0]                      obv;   // Output buffer valids
		wcb_pkg::beat_t [1:0]            ob;    // Output buffer, head at 0
	} wcb_state_t;

	wcb_state_t s_reg;
	wcb_state_t s_next;

	// Line store ports
	logic                         mst_we;
	logic [wcb_pkg::MEM_AW-1:0]   mst_addr;
	logic [7:0]                   mst_be;
	logic                         mfl_we;
	logic [wcb_pkg::MEM_AW-1:0]   mfl_addr;
	logic [7:0]                   mfl_be;
	logic [wcb_pkg::MEM_AW-1:0]   mrd_addr;
	logic [63:0]                  mrd_data;

	// Decision helpers
	logic [3:0]                   active;   // Buffers enabled by strap
	logic [3:0]                   acc_lim;  // Accumulating limit
	logic [3:0]                   acc_cnt;  // Buffers accumulating
	logic                         hit;
	logic [wcb_pkg::BUF_W-1:0]    hit_idx;
	logic                         draining_match;
	logic                         free_ok;
	logic [wcb_pkg::BUF_W-1:0]    free_idx;
	logic                         vic_ok;
	logic [wcb_pkg::BUF_W-1:0]    vic_idx;
	logic                         space;    // Output buffer can take one
	logic                         push_v;
	wcb_pkg::beat_t               push_b;
	logic                         done;     // Drain of a buffer finished
	logic [7:0]                   qmask;
	logic                         dfull;

	// ---------------------------------------------------------------
	// Line store
	// ---------------------------------------------------------------
	wcb_line_store line_store (
		.clk     (clk),
		.st_we   (mst_we),
		.st_addr (mst_addr),
		.st_be   (mst_be),
		.st_data (s_reg.st.data),
		.fl_we   (mfl_we),
		.fl_addr (mfl_addr),
		.fl_be   (mfl_be),
		.fl_data (fill_in.data),
		.rd_addr (mrd_addr),
		.rd_data (mrd_data)
	);

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		s_next   = s_reg;
		mst_we   = 1'b0;
		mst_addr = {s_reg.b[0].line[2:0], s_reg.st.qword};
		mst_be   = s_reg.st.be;
		mfl_we   = 1'b0;
		mfl_addr = {fill_in.slot, fill_in.qword};
		mfl_be   = 8'h0;
		mrd_addr = {s_reg.dslot, s_reg.dq};
		push_v   = 1'b0;
		push_b   = '0;
		done     = 1'b0;
		// Six or eight buffers by revision strap
		active = s_reg.eight ? 4'(wcb_pkg::LATE_BUF)
			: 4'(wcb_pkg::BASE_BUF);
		// Keep two buffers' worth of room for draining ones
		acc_lim = active - 4'(wcb_pkg::DRAIN_RESERVE);

		// Survey buffers: hit, free slot, victim, accumulating count
		acc_cnt = 4'h0;
		hit = 1'b0;
		hit_idx = '0;
		draining_match = 1'b0;
		free_ok = 1'b0;
		free_idx = '0;
		vic_ok = 1'b0;
		vic_idx = '0;
		for (int i = wcb_pkg::NUM_BUF - 1; i >= 0; i--) begin
			if (4'(i) < active) begin
				if (!s_reg.b[i].valid) begin
					free_ok = 1'b1;
					free_idx = 3'(i);
				end else if (s_reg.b[i].evict) begin
					if (s_reg.b[i].line == s_reg.st.line) begin
						draining_match = 1'b1;
					end
				end else begin
					acc_cnt = acc_cnt + 4'h1;
					if (s_reg.b[i].line == s_reg.st.line) begin
						hit = 1'b1;
						hit_idx = 3'(i);
					end
					// Only merged or combining lines may leave
					if (s_reg.b[i].own == wcb_pkg::own_none) begin
						vic_ok = 1'b1;
						vic_idx = 3'(i);
					end
				end
			end
		end

		// Output buffer: pop the head toward the bus
		if (s_reg.obv[0] && wr_ready) begin
			s_next.ob[0] = s_reg.ob[1];
			s_next.obv = {1'b0, s_reg.obv[1]};
		end
		space = !s_next.obv[1];

		// Ownership read accepted: hold every other cacheable line
		if (s_reg.own_v && own_ready) begin
			s_next.own_v = 1'b0;
			s_next.b[s_reg.own.slot].own = wcb_pkg::own_issued;
			for (int i = 0; i < wcb_pkg::NUM_BUF; i++) begin
				if (3'(i) != s_reg.own.slot && s_reg.b[i].valid
					&& s_reg.b[i].mtype == wcb_pkg::mt_writeback) begin
					s_next.blk[i][s_reg.own.slot] = 1'b1;
				end
			end
		end
		// Offer the next waiting ownership read, one at a time
		if (!s_next.own_v) begin
			for (int i = wcb_pkg::NUM_BUF - 1; i >= 0; i--) begin
				if (s_next.b[i].valid
					&& s_next.b[i].own == wcb_pkg::own_pending) begin
					s_next.own_v = 1'b1;
					s_next.own.slot = 3'(i);
					s_next.own.line = s_next.b[i].line;
				end
			end
		end

		// Fill data: only bytes the core has not written are taken
		if (fill_valid) begin
			mfl_we = 1'b1;
			mfl_be = ~s_reg.b[fill_in.slot].mask[{fill_in.qword, 3'h0} +: 8];
			if (fill_in.last) begin
				s_next.b[fill_in.slot].own = wcb_pkg::own_none;
				s_next.b[fill_in.slot].mask = wcb_pkg::MASK_FULL;
				s_next.b[fill_in.slot].evict = 1'b1;
				for (int i = 0; i < wcb_pkg::NUM_BUF; i++) begin
					s_next.blk[i][fill_in.slot] = 1'b0;
				end
			end
		end

		// Drain sequencer: full line as one burst, else chunks
		qmask = s_reg.b[s_reg.dslot].mask[{s_reg.dq, 3'h0} +: 8];
		dfull = &s_reg.b[s_reg.dslot].mask;
		unique case (s_reg.dr)
			wcb_pkg::dr_idle: begin
				for (int i = wcb_pkg::NUM_BUF - 1; i >= 0; i--) begin
					if (s_reg.b[i].valid && s_reg.b[i].evict) begin
						s_next.dslot = 3'(i);
						s_next.dr = wcb_pkg::dr_load;
					end
				end
				s_next.dq = 3'h0;
			end
			wcb_pkg::dr_load: begin
				// Unwritten quadwords of a partial line are skipped
				if (!dfull && qmask == 8'h0) begin
					if (s_reg.dq == wcb_pkg::QW_LAST) begin
						done = 1'b1;
					end else begin
						s_next.dq = s_reg.dq + 3'h1;
					end
				end else begin
					s_next.dr = wcb_pkg::dr_send;
				end
			end
			wcb_pkg::dr_send: begin
				if (space) begin
					push_v = 1'b1;
					push_b.line = s_reg.b[s_reg.dslot].line;
					push_b.qword = s_reg.dq;
					push_b.data = mrd_data;
					push_b.be = dfull ? wcb_pkg::BE_ALL : qmask;
					push_b.full = dfull;
					// Each chunk is its own transaction when not full
					push_b.last = dfull
						? (s_reg.dq == wcb_pkg::QW_LAST)
						: 1'b1;
					if (s_reg.dq == wcb_pkg::QW_LAST) begin
						done = 1'b1;
					end else begin
						s_next.dq = s_reg.dq + 3'h1;
						s_next.dr = wcb_pkg::dr_load;
					end
				end
			end
		endcase
		// Release the drained buffer and its holds
		if (done) begin
			s_next.dr = wcb_pkg::dr_idle;
			s_next.b[s_reg.dslot] = '0;
			for (int i = 0; i < wcb_pkg::NUM_BUF; i++) begin
				s_next.blk[i][s_reg.dslot] = 1'b0;
				s_next.blk[s_reg.dslot][i] = 1'b0;
			end
		end

		// Held store: bypass, merge, allocate or force an eviction
		if (s_reg.pend) begin
			if (s_reg.st.mtype == wcb_pkg::mt_uncacheable) begin
				// Uncacheable goes straight out as one partial write
				if (!push_v && space) begin
					push_v = 1'b1;
					push_b.line = s_reg.st.line;
					push_b.qword = s_reg.st.qword;
					push_b.data = s_reg.st.data;
					push_b.be = s_reg.st.be;
					push_b.full = 1'b0;
					push_b.last = 1'b1;
					s_next.pend = 1'b0;
				end
			end else if (hit) begin
				// Hold the line while a later ownership read is out
				if (!(|s_reg.blk[hit_idx])) begin
					mst_we = 1'b1;
					mst_addr = {hit_idx, s_reg.st.qword};
					s_next.b[hit_idx].mask[{s_reg.st.qword, 3'h0} +: 8] =
						s_next.b[hit_idx].mask[{s_reg.st.qword, 3'h0} +: 8]
						| s_reg.st.be;
					if (&s_next.b[hit_idx].mask
						&& s_reg.b[hit_idx].own == wcb_pkg::own_none) begin
						s_next.b[hit_idx].evict = 1'b1;
					end
					s_next.pend = 1'b0;
				end
			end else if (draining_match) begin
				// Wait so the older copy of this line reaches the bus first
				s_next.pend = 1'b1;
			end else if (free_ok && acc_cnt < acc_lim) begin
				mst_we = 1'b1;
				mst_addr = {free_idx, s_reg.st.qword};
				s_next.b[free_idx].valid = 1'b1;
				s_next.b[free_idx].line = s_reg.st.line;
				s_next.b[free_idx].mtype = s_reg.st.mtype;
				s_next.b[free_idx].mask = wcb_pkg::MASK_EMPTY;
				s_next.b[free_idx].mask[{s_reg.st.qword, 3'h0} +: 8] =
					s_reg.st.be;
				s_next.b[free_idx].evict = 1'b0;
				// Cacheable lines need ownership; combining lines do not
				s_next.b[free_idx].own =
					(s_reg.st.mtype == wcb_pkg::mt_writeback)
					? wcb_pkg::own_pending
					: wcb_pkg::own_none;
				for (int i = 0; i < wcb_pkg::NUM_BUF; i++) begin
					s_next.blk[free_idx][i] = 1'b0;
				end
				s_next.pend = 1'b0;
			end else if (vic_ok) begin
				// No room: push one line out, retry the store later
				s_next.b[vic_idx].evict = 1'b1;
			end
		end

		// Load the output buffer behind any entry still waiting
		if (push_v) begin
			if (!s_next.obv[0]) begin
				s_next.ob[0] = push_b;
				s_next.obv[0] = 1'b1;
			end else begin
				s_next.ob[1] = push_b;
				s_next.obv[1] = 1'b1;
			end
		end

		// Store port takes a new store only when none is held
		if (s_reg.rdy && st_valid) begin
			s_next.pend = 1'b1;
			s_next.st = st_in;
		end
		s_next.rdy = !s_next.pend;

		// Strap is caught on every reset cycle
		if (rst) begin
			s_next = '0;
			s_next.eight = late_rev;
		end
	end

	// Registers
	always_ff @(posedge clk) begin
		s_reg <= s_next;
	end

	// ---------------------------------------------------------------
	// Outputs, all straight from state
	// ---------------------------------------------------------------
	assign st_ready  = s_reg.rdy;
	assign own_valid = s_reg.own_v;
	assign own_req   = s_reg.own;
	assign wr_valid  = s_reg.obv[0];
	assign wr_beat   = s_reg.ob[0];

endmodule // write_combining_buffers

/* File: verif/wcb_properties.sv */
// Port checks for the write-combining buffer block
`timescale 1ns/100ps
module wcb_properties (
	input wire logic              clk,
	input wire logic              rst,
	input wire logic              late_rev,
	input wire logic              st_valid,
	input wire wcb_pkg::store_t   st_in,
	input wire logic              st_ready,
	input wire logic              own_valid,
	input wire wcb_pkg::own_req_t own_req,
	input wire logic              own_ready,
	input wire logic              fill_valid,
	input wire wcb_pkg::fill_t    fill_in,
	input wire logic              wr_valid,
	input wire wcb_pkg::beat_t    wr_beat,
	input wire logic              wr_ready
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic [2:0] qw_reg; // Quadword due next in a full line
	// Wraps after qword 7, so a new line must restart at 0
	always_ff @(posedge clk) begin
		if (rst)
			qw_reg <= 3'h0;
		else if (wr_valid && wr_ready && wr_beat.full)
			qw_reg <= wr_beat.qword + 3'h1;
	end
	sequence s_st_take;
		st_valid && st_ready;
	endsequence
	sequence s_own_take;
		own_valid && own_ready;
	endsequence
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	AST_RESET_IDLE: assert property (
		$fell(rst) |-> !st_ready && !own_valid && !wr_valid)
		else $error("outputs busy at reset release");
	AST_READY_AFTER_RESET: assert property (
		$fell(rst) |=> st_ready) else $error("store port not ready");
	AST_ONE_STORE: assert property (
		s_st_take |=> !st_ready) else $error("store port stayed ready");
	AST_OWN_STAND: assert property (
		own_valid && !own_ready |=> own_valid && $stable(own_req))
		else $error("ownership read changed before taken");
	AST_OWN_NEXT: assert property (
		s_own_take |=> !own_valid || own_req != $past(own_req))
		else $error("ownership read offered twice");
	AST_WR_STAND: assert property (
		wr_valid && !wr_ready |=> wr_valid && $stable(wr_beat))
		else $error("write beat changed before taken");
	AST_FULL_FORM: assert property (
		wr_valid && wr_beat.full |-> wr_beat.be == wcb_pkg::BE_ALL
		&& wr_beat.last == (wr_beat.qword == wcb_pkg::QW_LAST))
		else $error("full line beat malformed");
	AST_FULL_ORDER: assert property (
		wr_valid && wr_beat.full |-> wr_beat.qword == qw_reg)
		else $error("full line beats out of order");
	AST_PART_FORM: assert property (
		wr_valid && !wr_beat.full |-> wr_beat.last && wr_beat.be != 8'h00)
		else $error("partial beat malformed");
endmodule // wcb_properties

/* File: verif/wcb_far_model.sv */
// Outer hierarchy model: takes ownership reads, returns fills, sinks writes
`timescale 1ns/100ps
module wcb_far_model (
	input  wire logic              clk,
	input  wire logic              hold_wr,
	input  wire logic              slow,
	input  wire logic              own_valid,
	input  wire wcb_pkg::own_req_t own_req,
	output logic                   own_ready,
	output logic                   fill_valid,
	output wcb_pkg::fill_t         fill_in,
	input  wire logic              wr_valid,
	output logic                   wr_ready
);
	wcb_pkg::own_req_t req_q[$]; // Reads taken, fills still owed
	wcb_pkg::own_req_t cur;      // Read being filled
	logic [2:0]        cyc;      // Free count for slow answers
	initial begin
		own_ready = 1'b0;
		fill_valid = 1'b0;
		fill_in = '0;
		wr_ready = 1'b0;
		cyc = 3'h0;
	end
	// Accept reads on odd cycles only, so the design must hold its offer
	always @(posedge clk) begin
		cyc <= cyc + 3'h1;
		if (own_valid && own_ready)
			req_q.push_back(own_req);
		own_ready <= own_valid && !own_ready && cyc[0];
		wr_ready <= !hold_wr && (!slow || cyc[1]);
	end
	// Whole line per read, highest quadword first; data idles inverted
	always begin
		@(posedge clk);
		if (req_q.size() != 0) begin
			cur = req_q.pop_front();
			repeat (4) @(posedge clk);
			for (int i = 7; i >= 0; i--) begin
				fill_valid <= 1'b1;
				fill_in <= '{cur.slot, 3'(i), {30'h0, cur.line, 5'h0, 3'(i)},
					i == 0};
				@(posedge clk);
			end
			fill_valid <= 1'b0;
			fill_in <= ~fill_in;
		end
	end
endmodule // wcb_far_model

/* File: verif/tb_write_combining_buffers.sv */
// Self-checking bench for the write-combining buffer block
`timescale 1ns/100ps
module tb_write_combining_buffers;
	logic clk, rst, late_rev, st_valid, st_ready, own_valid, own_ready;
	logic fill_valid, wr_valid, wr_ready, hold_wr, slow;
	wcb_pkg::store_t   st_in;    // Store offered
	wcb_pkg::own_req_t own_req;  // Ownership read out
	wcb_pkg::fill_t    fill_in;  // Fill beat back
	wcb_pkg::beat_t    wr_beat;  // Write beat out
	wcb_pkg::beat_t    beats[$]; // Beats the far side took
	wcb_pkg::own_req_t owns[$];  // Reads the far side took
	int mismatches, checks_done, lasts, cycles;
	write_combining_buffers dut (.clk(clk), .rst(rst), .late_rev(late_rev),
		.st_valid(st_valid), .st_in(st_in), .st_ready(st_ready),
		.own_valid(own_valid), .own_req(own_req), .own_ready(own_ready),
		.fill_valid(fill_valid), .fill_in(fill_in), .wr_valid(wr_valid),
		.wr_beat(wr_beat), .wr_ready(wr_ready));
	wcb_far_model far (.clk(clk), .hold_wr(hold_wr), .slow(slow),
		.own_valid(own_valid), .own_req(own_req), .own_ready(own_ready),
		.fill_valid(fill_valid), .fill_in(fill_in), .wr_valid(wr_valid),
		.wr_ready(wr_ready));
	// ------------------------------------------------------------
	// Clock, monitor and hang limit
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (wr_valid && wr_ready)
			beats.push_back(wr_beat);
		if (own_valid && own_ready)
			owns.push_back(own_req);
		if (fill_valid && fill_in.last)
			lasts <= lasts + 1;
		if (cycles == 20000) begin
			mismatches = mismatches + 1;
			finish_test();
		end
	end
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [63:0] sdat(logic [25:0] ln, logic [2:0] q);
		return {16'hbeef, ln[15:0], 29'h0, q};
	endfunction
	function automatic logic [63:0] bm(logic [7:0] be);
		for (int b = 0; b < 8; b++)
			bm[8*b+:8] = {8{be[b]}};
	endfunction
	task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
		checks_done = checks_done + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic do_reset(input logic rev);
		rst <= 1'b1;
		late_rev <= rev;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		beats.delete();
		owns.delete();
	endtask
	// One store, held until taken
	task automatic put(input logic [25:0] ln, input logic [2:0] q,
		input logic [7:0] be, input wcb_pkg::mem_type_t mt);
		st_valid <= 1'b1;
		st_in <= '{ln, q, sdat(ln, q), be, mt};
		do @(posedge clk); while (st_ready !== 1'b1);
		st_valid <= 1'b0;
		@(posedge clk);
	endtask
	// Oldest beat of a line; only written bytes are compared
	task automatic expect_beat(input logic [25:0] ln, input logic [2:0] q,
		input logic [7:0] be, input logic full, input logic [63:0] d);
		int k;
		k = -1;
		while (k < 0) begin
			foreach (beats[i]) if (k < 0 && beats[i].line === ln) k = i;
			if (k < 0) @(posedge clk);
		end
		cmp(beats[k].qword, q);
		cmp(beats[k].be, be);
		cmp(beats[k].full, full);
		cmp(beats[k].last, !full || q == 3'h7);
		cmp(beats[k].data & bm(be), d & bm(be));
		beats.delete(k);
	endtask
	// Full line of stored bytes over fill bytes
	task automatic expect_line(input logic [25:0] ln, input logic [2:0] qa,
		input logic [7:0] ba, input logic [2:0] qb, input logic [7:0] bb);
		logic [63:0] m;
		for (int q = 0; q < 8; q++) begin
			m = bm(q == qa ? ba : 8'h00) | bm(q == qb ? bb : 8'h00);
			expect_beat(ln, 3'(q), 8'hff, 1'b1, (sdat(ln, 3'(q)) & m)
				| ({30'h0, ln, 5'h0, 3'(q)} & ~m));
		end
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Uncacheable stores pass straight out; full buffer stalls the port
	task automatic t_bypass();
		hold_wr <= 1'b1;
		for (int i = 0; i < 3; i++)
			put(26'h100 + 26'(i), 3'(i), 8'h0f, wcb_pkg::mt_uncacheable);
		st_valid <= 1'b1;
		st_in <= '{26'h103, 3'h3, sdat(26'h103, 3'h3), 8'h0f,
			wcb_pkg::mt_uncacheable};
		repeat (10) @(posedge clk);
		cmp(st_ready, 1'b0);
		hold_wr <= 1'b0;
		do @(posedge clk); while (st_ready !== 1'b1);
		st_valid <= 1'b0;
		for (int i = 0; i < 4; i++)
			expect_beat(26'h100 + 26'(i), 3'(i), 8'h0f, 1'b0,
				sdat(26'h100 + 26'(i), 3'(i)));
	endtask
	// Combining line written whole leaves as one write, no read
	task automatic t_full();
		for (int q = 0; q < 8; q++)
			put(26'h200, 3'(q), 8'hff, wcb_pkg::mt_combining);
		for (int q = 0; q < 8; q++)
			expect_beat(26'h200, 3'(q), 8'hff, 1'b1, sdat(26'h200, 3'(q)));
		repeat (20) @(posedge clk);
		cmp(owns.size(), 0);
	endtask
	// Two writeback lines: first line held until second fill ends
	task automatic t_own();
		int n0;
		n0 = lasts;
		slow <= 1'b1;
		put(26'h400, 3'h1, 8'h0f, wcb_pkg::mt_writeback);
		put(26'h401, 3'h6, 8'hff, wcb_pkg::mt_writeback);
		while (owns.size() < 2) @(posedge clk);
		cmp(owns[0].line, 26'h400);
		cmp(owns[1].line, 26'h401);
		put(26'h400, 3'h2, 8'hf0, wcb_pkg::mt_writeback);
		// Held store is decided only once both fills are in
		do @(posedge clk); while (st_ready !== 1'b1);
		cmp(lasts - n0, 2);
		// First line leaves without the held bytes, which start a new line
		expect_line(26'h400, 3'h1, 8'h0f, 3'h1, 8'h0f);
		expect_line(26'h401, 3'h6, 8'hff, 3'h6, 8'hff);
		expect_line(26'h400, 3'h2, 8'hf0, 3'h2, 8'hf0);
		cmp(owns[2].line, 26'h400);
		slow <= 1'b0;
	endtask
	// Fill every accumulating buffer, then one more evicts the oldest
	task automatic t_cap(input logic rev, input int n);
		do_reset(rev);
		for (int q = 0; q < 8; q++)
			put(26'h300, 3'(q), q == 7 ? 8'h7f : 8'hff, wcb_pkg::mt_combining);
		for (int i = 1; i < n; i++)
			put(26'h300 + 26'(i), 3'h3, 8'h01, wcb_pkg::mt_combining);
		repeat (30) @(posedge clk);
		cmp(beats.size(), 0);
		put(26'h300 + 26'(n), 3'h3, 8'h01, wcb_pkg::mt_combining);
		for (int q = 0; q < 8; q++)
			expect_beat(26'h300, 3'(q), q == 7 ? 8'h7f : 8'hff, 1'b0,
				sdat(26'h300, 3'(q)));
	endtask
	task automatic finish_test();
		if (mismatches == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		rst = 1'b1;
		late_rev = 1'b0;
		st_valid = 1'b0;
		st_in = '0;
		hold_wr = 1'b0;
		slow = 1'b0;
		mismatches = 0;
		checks_done = 0;
		lasts = 0;
		cycles = 0;
		do_reset(1'b0);
		t_bypass();
		t_full();
		t_own();
		t_cap(1'b0, 4);
		t_cap(1'b1, 6);
		finish_test();
	end
endmodule // tb_write_combining_buffers
bind write_combining_buffers wcb_properties u_props (.clk(clk), .rst(rst),
	.late_rev(late_rev), .st_valid(st_valid), .st_in(st_in),
	.st_ready(st_ready), .own_valid(own_valid), .own_req(own_req),
	.own_ready(own_ready), .fill_valid(fill_valid), .fill_in(fill_in),
	.wr_valid(wr_valid), .wr_beat(wr_beat), .wr_ready(wr_ready));
